// ===== hdl/t3sa_top.sv
`timescale 1ns/10ps
// Timer 3 with split 8-bit or 16-bit auto-reload operation and oscillator capture.
module t3sa_top
  import t3sa_pkg::*;
(
  // Clock, reset and enable.
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic CE_IN,
  // Special function register port.
  input wire logic [7:0] SFR_ADDR_IN,
  input wire logic SFR_WR_IN,
  input wire logic [7:0] SFR_WDATA_IN,
  output logic [7:0] SFR_RDATA_OUT,
  // Clock-select bits held in the clock control register and interrupt enable.
  input wire logic HIGH_BYTE_FAST_CLOCK_SELECT_IN,
  input wire logic LOW_BYTE_FAST_CLOCK_SELECT_IN,
  input wire logic TIMER_IRQ_ENABLE_IN,
  // Count sources.
  input wire logic EXT_CLOCK_IN,
  input wire logic LOW_FREQUENCY_OSCILLATOR_IN,
  // Interrupt request.
  output logic TIMER_IRQ_OUT
);

  // ****************************************************************
  // Reset release and state.
  // ****************************************************************
  logic rst_meta_reg;
  logic rst_n;
  logic high_overflow_flag_reg;
  logic low_overflow_flag_reg;
  logic low_overflow_irq_enable_reg;
  logic slow_osc_capture_enable_reg;
  logic split_mode_enable_reg;
  logic high_byte_run_reg;
  t3sa_alt_t alt_clock_select_reg;
  logic [7:0] count_low_byte_reg;
  logic [7:0] count_high_byte_reg;
  logic [7:0] reload_low_byte_reg;
  logic [7:0] reload_high_byte_reg;
  logic high_flag_next;
  logic low_flag_next;
  logic tick_low;
  logic tick_high;
  logic step_low;
  logic inc_high;
  logic ovf_low;
  logic ovf_high;
  logic capture;
  logic wr_ctrl;
  logic wr_rl_low;
  logic wr_rl_high;
  logic wr_cnt_low;
  logic wr_cnt_high;
  logic [7:0] ctrl_view;

  t3sa_tick_if ticks ();

  // The reset is released through two flops.
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  t3sa_tick_gen u_tick_gen (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(rst_n),
    .ce_in(CE_IN),
    .ext_clk_in(EXT_CLOCK_IN),
    .osc_in(LOW_FREQUENCY_OSCILLATOR_IN),
    .tick_if(ticks.src)
  );

  // ****************************************************************
  // Clock selection and count steps.
  // ****************************************************************
  // Returns the count strobe for one byte from its fast select and the shared field.
  function automatic logic pick_tick(input logic fast, input t3sa_alt_t alt,
                                     input logic t12, input logic t8, input logic tosc);
    logic t;
    t = 1'b0;
    if (fast) begin
      t = 1'b1;
    end else begin
      case (alt)
        T3SA_ALT_DIV12: t = t12;
        T3SA_ALT_EXT8: t = t8;
        T3SA_ALT_OSC: t = tosc;
        default: t = 1'b0;
      endcase
    end
    return t;
  endfunction

  // Each byte has its own fast select but both share the alternate field; the reserved code gives no alternate steps.
  assign tick_high = pick_tick(HIGH_BYTE_FAST_CLOCK_SELECT_IN, alt_clock_select_reg,
    ticks.tick_div12, ticks.tick_ext8, ticks.tick_osc);
  assign tick_low = pick_tick(LOW_BYTE_FAST_CLOCK_SELECT_IN, alt_clock_select_reg,
    ticks.tick_div12, ticks.tick_ext8, ticks.tick_osc);

  // Split mode frees the low byte from the run bit; 16-bit mode chains the bytes.
  assign step_low = split_mode_enable_reg ? tick_low : (high_byte_run_reg & tick_low);
  assign inc_high = split_mode_enable_reg ? (high_byte_run_reg & tick_high) : ovf_low;
  assign ovf_low = step_low & (count_low_byte_reg == T3SA_BYTE_MAX);
  assign ovf_high = inc_high & (count_high_byte_reg == T3SA_BYTE_MAX);
  assign capture = slow_osc_capture_enable_reg & ticks.osc_fall;

  // Register write strobes.
  assign wr_ctrl = SFR_WR_IN & (SFR_ADDR_IN == T3SA_ADDR_CTRL);
  assign wr_rl_low = SFR_WR_IN & (SFR_ADDR_IN == T3SA_ADDR_RELOAD_LOW);
  assign wr_rl_high = SFR_WR_IN & (SFR_ADDR_IN == T3SA_ADDR_RELOAD_HIGH);
  assign wr_cnt_low = SFR_WR_IN & (SFR_ADDR_IN == T3SA_ADDR_COUNT_LOW);
  assign wr_cnt_high = SFR_WR_IN & (SFR_ADDR_IN == T3SA_ADDR_COUNT_HIGH);

  // Hardware sets win over a software clear in the same cycle; capture marks the high flag.
  assign high_flag_next = (wr_ctrl ? SFR_WDATA_IN[T3SA_BIT_HIGH_FLAG] : high_overflow_flag_reg)
    | ovf_high | capture;
  assign low_flag_next = (wr_ctrl ? SFR_WDATA_IN[T3SA_BIT_LOW_FLAG] : low_overflow_flag_reg)
    | ovf_low;

  assign ctrl_view = {high_overflow_flag_reg, low_overflow_flag_reg, low_overflow_irq_enable_reg,
    slow_osc_capture_enable_reg, split_mode_enable_reg, high_byte_run_reg, alt_clock_select_reg};

  // ****************************************************************
  // Control register.
  // ****************************************************************
  // Flags only change through an overflow, a capture or a software write.
  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      {high_overflow_flag_reg, low_overflow_flag_reg, low_overflow_irq_enable_reg,
       slow_osc_capture_enable_reg, split_mode_enable_reg, high_byte_run_reg,
       alt_clock_select_reg} <= T3SA_CTRL_RESET;
    end else if (CE_IN) begin
      high_overflow_flag_reg <= high_flag_next;
      low_overflow_flag_reg <= low_flag_next;
      if (wr_ctrl) begin
        low_overflow_irq_enable_reg <= SFR_WDATA_IN[T3SA_BIT_LOW_IRQ_EN];
        slow_osc_capture_enable_reg <= SFR_WDATA_IN[T3SA_BIT_CAPTURE_EN];
        split_mode_enable_reg <= SFR_WDATA_IN[T3SA_BIT_SPLIT];
        high_byte_run_reg <= SFR_WDATA_IN[T3SA_BIT_RUN];
        alt_clock_select_reg <= SFR_WDATA_IN[T3SA_ALT_MSB:T3SA_ALT_LSB];
      end
    end
  end

  // ****************************************************************
  // Counters and reload registers.
  // ****************************************************************
  // A software write beats counting; an overflow reloads in the step that flags it, except a 16-bit low rollover without high overflow, which loads zero.
  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      count_low_byte_reg <= T3SA_BYTE_RESET;
      count_high_byte_reg <= T3SA_BYTE_RESET;
    end else if (CE_IN) begin
      if (wr_cnt_low) begin
        count_low_byte_reg <= SFR_WDATA_IN;
      end else if (ovf_low) begin
        count_low_byte_reg <= (split_mode_enable_reg | ovf_high) ?
          reload_low_byte_reg : T3SA_BYTE_RESET;
      end else if (step_low) begin
        count_low_byte_reg <= count_low_byte_reg + 8'h01;
      end
      if (wr_cnt_high) begin
        count_high_byte_reg <= SFR_WDATA_IN;
      end else if (ovf_high) begin
        count_high_byte_reg <= reload_high_byte_reg;
      end else if (inc_high) begin
        count_high_byte_reg <= count_high_byte_reg + 8'h01;
      end
    end
  end

  // Capture takes the reload pair ahead of a software write.
  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      reload_low_byte_reg <= T3SA_BYTE_RESET;
      reload_high_byte_reg <= T3SA_BYTE_RESET;
    end else if (CE_IN) begin
      if (capture) begin
        reload_low_byte_reg <= count_low_byte_reg;
        reload_high_byte_reg <= count_high_byte_reg;
      end else begin
        if (wr_rl_low) begin
          reload_low_byte_reg <= SFR_WDATA_IN;
        end
        if (wr_rl_high) begin
          reload_high_byte_reg <= SFR_WDATA_IN;
        end
      end
    end
  end

  // ****************************************************************
  // Read data and interrupt.
  // ****************************************************************
  // Read data follows the address one cycle later; unmapped addresses read zero.
  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      SFR_RDATA_OUT <= 8'h00;
    end else if (CE_IN) begin
      case (SFR_ADDR_IN)
        T3SA_ADDR_CTRL: SFR_RDATA_OUT <= ctrl_view;
        T3SA_ADDR_RELOAD_LOW: SFR_RDATA_OUT <= reload_low_byte_reg;
        T3SA_ADDR_RELOAD_HIGH: SFR_RDATA_OUT <= reload_high_byte_reg;
        T3SA_ADDR_COUNT_LOW: SFR_RDATA_OUT <= count_low_byte_reg;
        T3SA_ADDR_COUNT_HIGH: SFR_RDATA_OUT <= count_high_byte_reg;
        default: SFR_RDATA_OUT <= 8'h00;
      endcase
    end
  end

  // The request is a level that follows the flags and their enables.
  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      TIMER_IRQ_OUT <= 1'b0;
    end else if (CE_IN) begin
      TIMER_IRQ_OUT <= TIMER_IRQ_ENABLE_IN &
        (high_flag_next | (low_overflow_irq_enable_reg & low_flag_next));
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!rst_n);

  split_low_count_a: assert property (CE_IN && split_mode_enable_reg && tick_low && !wr_cnt_low
    && count_low_byte_reg != T3SA_BYTE_MAX |=> count_low_byte_reg == 8'($past(count_low_byte_reg) + 8'h01))
    else $error("Low byte did not count in split mode.");
  high_run_gate_a: assert property (CE_IN && split_mode_enable_reg && !high_byte_run_reg
    && !wr_cnt_high |=> $stable(count_high_byte_reg))
    else $error("High byte counted while stopped.");
  low_reload_a: assert property (CE_IN && split_mode_enable_reg && step_low && !wr_cnt_low
    && count_low_byte_reg == T3SA_BYTE_MAX |=> count_low_byte_reg == $past(reload_low_byte_reg)
    && low_overflow_flag_reg)
    else $error("Low byte overflow did not reload and flag.");
  fast_high_a: assert property (CE_IN && split_mode_enable_reg && high_byte_run_reg
    && HIGH_BYTE_FAST_CLOCK_SELECT_IN && !wr_cnt_high && count_high_byte_reg != T3SA_BYTE_MAX
    |=> count_high_byte_reg == 8'($past(count_high_byte_reg) + 8'h01))
    else $error("High byte ignored the system clock select.");
  high_flag_set_a: assert property (CE_IN && ovf_high && !wr_cnt_high |=> high_overflow_flag_reg
    && count_high_byte_reg == $past(reload_high_byte_reg))
    else $error("High overflow did not set the flag.");
  full_roll_a: assert property (CE_IN && !split_mode_enable_reg && step_low
    && count_low_byte_reg == T3SA_BYTE_MAX && count_high_byte_reg == T3SA_BYTE_MAX
    && !wr_cnt_low && !wr_cnt_high |=> high_overflow_flag_reg
    && count_low_byte_reg == $past(reload_low_byte_reg))
    else $error("16-bit rollover not handled.");
  flag_sticky_a: assert property (CE_IN && !wr_ctrl && low_overflow_flag_reg
    |=> low_overflow_flag_reg)
    else $error("Low flag cleared by hardware.");
  capture_copy_a: assert property (CE_IN && capture |=>
    reload_low_byte_reg == $past(count_low_byte_reg)
    && reload_high_byte_reg == $past(count_high_byte_reg))
    else $error("Capture did not copy the counter.");
  irq_high_a: assert property (CE_IN && TIMER_IRQ_ENABLE_IN && high_overflow_flag_reg
    && !wr_ctrl |=> TIMER_IRQ_OUT)
    else $error("High flag raised no interrupt.");
  irq_low_a: assert property (CE_IN && TIMER_IRQ_ENABLE_IN && !wr_ctrl && !ovf_high && !capture
    && low_overflow_flag_reg && !high_overflow_flag_reg |=> TIMER_IRQ_OUT == $past(low_overflow_irq_enable_reg))
    else $error("Low interrupt enable not obeyed.");

  split_ovf_c: cover property (CE_IN && split_mode_enable_reg && ovf_low);
  wide_ovf_c: cover property (CE_IN && !split_mode_enable_reg && ovf_high);
  capture_c: cover property (CE_IN && capture ##1 TIMER_IRQ_OUT);

endmodule

// ===== hdl/t3sa_pkg.sv
// Notes on behaviour
// - Split mode runs two separate 8-bit counters, each reloading from its own reload byte.
// - In split mode the run bit gates only the high byte; low byte always counts.
// - In split mode the high byte uses system clock when fast select is 1, else alternate source; in 16-bit mode it counts low byte rollovers.
// - Low byte has its own fast select but shares the alternate source field with the high byte.
// - High overflow flag sets when the high byte rolls over from all ones and reloads from its reload byte.
// - In 16-bit mode the high flag sets when the whole counter rolls over.
// - Low overflow flag sets on every low byte rollover, in either mode.
// - With the timer interrupt enabled, every high overflow requests an interrupt.
// - With low interrupt enable also set, each low overflow requests an interrupt too.
// - Hardware never clears an overflow flag; only a software write of zero does.
// - Capture copies the counter into the reload pair on oscillator falling edges.
// - With split mode cleared the timer runs as one 16-bit auto-reload counter.
// - External and oscillator count sources are synchronised to the system clock first.
package t3sa_pkg;

  // ****************************************************************
  // Register addresses on the special function register port.
  // ****************************************************************
  localparam logic [7:0] T3SA_ADDR_CTRL = 8'h91;
  localparam logic [7:0] T3SA_ADDR_RELOAD_LOW = 8'h92;
  localparam logic [7:0] T3SA_ADDR_RELOAD_HIGH = 8'h93;
  localparam logic [7:0] T3SA_ADDR_COUNT_LOW = 8'h94;
  localparam logic [7:0] T3SA_ADDR_COUNT_HIGH = 8'h95;

  // ****************************************************************
  // Control register fields and reset values.
  // ****************************************************************
  localparam int T3SA_BIT_HIGH_FLAG = 7;
  localparam int T3SA_BIT_LOW_FLAG = 6;
  localparam int T3SA_BIT_LOW_IRQ_EN = 5;
  localparam int T3SA_BIT_CAPTURE_EN = 4;
  localparam int T3SA_BIT_SPLIT = 3;
  localparam int T3SA_BIT_RUN = 2;
  localparam int T3SA_ALT_MSB = 1;
  localparam int T3SA_ALT_LSB = 0;
  localparam logic [7:0] T3SA_CTRL_RESET = 8'h00;
  localparam logic [7:0] T3SA_BYTE_RESET = 8'h00;
  localparam logic [7:0] T3SA_BYTE_MAX = 8'hff;

  // ****************************************************************
  // Alternate clock source encoding.
  // ****************************************************************
  typedef logic [1:0] t3sa_alt_t;
  localparam t3sa_alt_t T3SA_ALT_DIV12 = 2'h0;
  localparam t3sa_alt_t T3SA_ALT_EXT8 = 2'h1;
  localparam t3sa_alt_t T3SA_ALT_RESERVED = 2'h2;
  localparam t3sa_alt_t T3SA_ALT_OSC = 2'h3;

  // ****************************************************************
  // Prescaler counts.
  // ****************************************************************
  localparam logic [3:0] T3SA_DIV12_LAST = 4'hb;
  localparam logic [2:0] T3SA_DIV8_LAST = 3'h7;

endpackage

// ===== hdl/t3sa_tick_if.sv
`timescale 1ns/10ps
// Count-step strobes passed from the tick generator to the timer core.
interface t3sa_tick_if;
  logic tick_div12;
  logic tick_ext8;
  logic tick_osc;
  logic osc_fall;

  modport src (output tick_div12, output tick_ext8, output tick_osc, output osc_fall);
  modport dst (input tick_div12, input tick_ext8, input tick_osc, input osc_fall);
endinterface

// ===== hdl/t3sa_tick_gen.sv
`timescale 1ns/10ps
// Synchronises the slow sources and builds the prescaled count strobes.
module t3sa_tick_gen
  import t3sa_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic ext_clk_in,
  input wire logic osc_in,
  t3sa_tick_if.src tick_if
);

  // ****************************************************************
  // Synchronisers.
  // ****************************************************************
  logic [1:0] meta_reg;
  logic [1:0] sync_reg;
  logic [1:0] prev_reg;
  logic [3:0] div12_reg;
  logic [2:0] div8_reg;
  logic ext_rise;

  // Two flops per source; only the second stage feeds the edge detectors.
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sync
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          meta_reg[g] <= 1'b0;
          sync_reg[g] <= 1'b0;
          prev_reg[g] <= 1'b0;
        end else if (ce_in) begin
          meta_reg[g] <= (g == 0) ? ext_clk_in : osc_in;
          sync_reg[g] <= meta_reg[g];
          prev_reg[g] <= sync_reg[g];
        end
      end
    end
  endgenerate

  assign ext_rise = sync_reg[0] & ~prev_reg[0];

  // ****************************************************************
  // Prescalers and strobes.
  // ****************************************************************
  // System clock divided by 12 and external clock edges divided by 8.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div12_reg <= 4'h0;
      div8_reg <= 3'h0;
      tick_if.tick_div12 <= 1'b0;
      tick_if.tick_ext8 <= 1'b0;
      tick_if.tick_osc <= 1'b0;
      tick_if.osc_fall <= 1'b0;
    end else if (ce_in) begin
      div12_reg <= (div12_reg == T3SA_DIV12_LAST) ? 4'h0 : div12_reg + 4'h1;
      tick_if.tick_div12 <= (div12_reg == T3SA_DIV12_LAST);
      if (ext_rise) begin
        div8_reg <= div8_reg + 3'h1;
      end
      tick_if.tick_ext8 <= ext_rise & (div8_reg == T3SA_DIV8_LAST);
      tick_if.tick_osc <= sync_reg[1] & ~prev_reg[1];
      tick_if.osc_fall <= ~sync_reg[1] & prev_reg[1];
    end
  end

endmodule

// ===== tb/timer3_split_autoreload_tb_top.sv
`timescale 1ns/10ps
module timer3_split_autoreload_tb_top import t3sa_pkg::*; ;

  // ****************************************************************
  // Stimulus signals and the design under test.
  // ****************************************************************
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic hfast = 1'b0;
  logic lfast = 1'b0;
  logic irq_en = 1'b0;
  logic ext = 1'b0;
  logic osc = 1'b0;
  wire [7:0] rdata;
  wire irq;
  int n_fail = 0;
  int checks = 0;

  // The clock toggles every half period of 5 ns.
  always #5 clk = ~clk;

  t3sa_top uut (
    .CORE_CLK_IN(clk),
    .RST_N_IN(rst_n),
    .CE_IN(ce),
    .SFR_ADDR_IN(addr),
    .SFR_WR_IN(wr),
    .SFR_WDATA_IN(wdata),
    .SFR_RDATA_OUT(rdata),
    .HIGH_BYTE_FAST_CLOCK_SELECT_IN(hfast),
    .LOW_BYTE_FAST_CLOCK_SELECT_IN(lfast),
    .TIMER_IRQ_ENABLE_IN(irq_en),
    .EXT_CLOCK_IN(ext),
    .LOW_FREQUENCY_OSCILLATOR_IN(osc),
    .TIMER_IRQ_OUT(irq)
  );

  // ****************************************************************
  // Shared bus and comparison tasks.
  // ****************************************************************
  // Compares a value within a range and counts the comparison.
  task automatic chk_rng(input string name, input logic [7:0] lo, input logic [7:0] hi,
                         input logic [7:0] got);
    checks++;
    if ($isunknown(got) || (got < lo) || (got > hi)) begin
      $display("Error %s expected %h..%h seen %h", name, lo, hi, got);
      n_fail++;
    end
  endtask

  // Exact comparison is a range of one value.
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    chk_rng(name, exp, exp, got);
  endtask

  // Writes one register; the strobe stands for one rising edge.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  // Reads one register; the data is registered one edge after the address.
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    d = rdata;
  endtask

  // Reads a register and compares it exactly.
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd_reg(a, d);
    chk(name, exp, d);
  endtask

  // Gives one byte exactly n fast count steps.
  task automatic steps(input bit high, input int n);
    @(negedge clk);
    if (high) hfast = 1'b1;
    else lfast = 1'b1;
    repeat (n) @(posedge clk);
    @(negedge clk);
    hfast = 1'b0;
    lfast = 1'b0;
  endtask

  // Samples the interrupt line after two settled cycles.
  task automatic chk_irq(input logic exp);
    repeat (2) @(negedge clk);
    chk("irq", {7'h00, exp}, {7'h00, irq});
  endtask

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_reset();
    rd_chk("ctrl", T3SA_ADDR_CTRL, 8'h00); // timer3_control
    rd_chk("reload_low", T3SA_ADDR_RELOAD_LOW, 8'h00);
    rd_chk("reload_high", T3SA_ADDR_RELOAD_HIGH, 8'h00);
    rd_chk("count_low", T3SA_ADDR_COUNT_LOW, 8'h00);
    rd_chk("count_high", T3SA_ADDR_COUNT_HIGH, 8'h00);
    wr_reg(8'h96, 8'h5a);
    rd_chk("unmapped", 8'h96, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_split_low();
    wr_reg(T3SA_ADDR_CTRL, 8'h0a);
    wr_reg(T3SA_ADDR_RELOAD_LOW, 8'hf0);
    wr_reg(T3SA_ADDR_COUNT_LOW, 8'hfd);
    wr_reg(T3SA_ADDR_COUNT_HIGH, 8'h10);
    steps(1'b0, 5);
    rd_chk("count_low", T3SA_ADDR_COUNT_LOW, 8'hf2);
    rd_chk("ctrl", T3SA_ADDR_CTRL, 8'h4a);
    rd_chk("count_high", T3SA_ADDR_COUNT_HIGH, 8'h10);
    repeat (50) @(negedge clk);
    rd_chk("ctrl", T3SA_ADDR_CTRL, 8'h4a);
    steps(1'b1, 4);
    rd_chk("count_high", T3SA_ADDR_COUNT_HIGH, 8'h10);
    wr_reg(T3SA_ADDR_CTRL, 8'h0a);
    rd_chk("ctrl", T3SA_ADDR_CTRL, 8'h0a);
    $display("test split low done");
  endtask

  task automatic t_split_high();
    wr_reg(T3SA_ADDR_RELOAD_HIGH, 8'h80);
    wr_reg(T3SA_ADDR_COUNT_HIGH, 8'hfe);
    wr_reg(T3SA_ADDR_CTRL, 8'h0e);
    steps(1'b1, 4);
    rd_chk("count_high", T3SA_ADDR_COUNT_HIGH, 8'h82);
    rd_chk("ctrl", T3SA_ADDR_CTRL, 8'h8e);
    rd_chk("count_low", T3SA_ADDR_COUNT_LOW, 8'hf2);
    @(negedge clk);
    ce = 1'b0;
    steps(1'b1, 4);
    ce = 1'b1;
    rd_chk("count_high_frozen", T3SA_ADDR_COUNT_HIGH, 8'h82);
    $display("test split high done");
  endtask

  task automatic t_irq();
    @(negedge clk);
    irq_en = 1'b1;
    chk_irq(1'b1);
    wr_reg(T3SA_ADDR_CTRL, 8'h4e);
    chk_irq(1'b0);
    wr_reg(T3SA_ADDR_CTRL, 8'h6e);
    chk_irq(1'b1);
    rd_chk("irq_source_flags", T3SA_ADDR_CTRL, 8'h6e);
    wr_reg(T3SA_ADDR_CTRL, 8'h0e);
    chk_irq(1'b0);
    irq_en = 1'b0;
    $display("test interrupt done");
  endtask

  task automatic t_16bit();
    logic [7:0] d;
    wr_reg(T3SA_ADDR_CTRL, 8'h06);
    wr_reg(T3SA_ADDR_RELOAD_LOW, 8'h34);
    wr_reg(T3SA_ADDR_RELOAD_HIGH, 8'h12);
    wr_reg(T3SA_ADDR_COUNT_LOW, 8'hfe);
    wr_reg(T3SA_ADDR_COUNT_HIGH, 8'h00);
    steps(1'b0, 2);
    rd_chk("count_low", T3SA_ADDR_COUNT_LOW, 8'h00);
    rd_chk("count_high", T3SA_ADDR_COUNT_HIGH, 8'h01);
    rd_chk("ctrl", T3SA_ADDR_CTRL, 8'h46);
    wr_reg(T3SA_ADDR_COUNT_LOW, 8'hfe);
    wr_reg(T3SA_ADDR_COUNT_HIGH, 8'hff);
    wr_reg(T3SA_ADDR_CTRL, 8'h06);
    steps(1'b0, 3);
    rd_chk("count_low", T3SA_ADDR_COUNT_LOW, 8'h35);
    rd_chk("count_high", T3SA_ADDR_COUNT_HIGH, 8'h12);
    rd_reg(T3SA_ADDR_CTRL, d);
    chk("high_flag", 8'h80, d & 8'h80);
    $display("test sixteen bit done");
  endtask

  // Each alternate source in turn clocks both bytes in split mode with run set.
  task automatic t_alt();
    logic [7:0] d;
    logic [7:0] lo[3] = '{8'h0a, 8'h02, 8'h05};
    logic [7:0] hi[3] = '{8'h0c, 8'h04, 8'h05};
    t3sa_alt_t sel[3] = '{T3SA_ALT_DIV12, T3SA_ALT_EXT8, T3SA_ALT_OSC};
    for (int i = 0; i < 3; i++) begin
      wr_reg(T3SA_ADDR_COUNT_LOW, 8'h00);
      wr_reg(T3SA_ADDR_COUNT_HIGH, 8'h00);
      wr_reg(T3SA_ADDR_CTRL, {6'b000011, sel[i]});
      if (i == 0) repeat (120) @(negedge clk);
      if (i == 1) repeat (48) begin
        repeat (2) @(negedge clk);
        ext = ~ext;
      end
      if (i == 2) repeat (10) begin
        repeat (6) @(negedge clk);
        osc = ~osc;
      end
      repeat (10) @(negedge clk);
      wr_reg(T3SA_ADDR_CTRL, 8'h0e);
      rd_reg(T3SA_ADDR_COUNT_LOW, d);
      chk_rng("alt_low", lo[i], hi[i], d);
      rd_reg(T3SA_ADDR_COUNT_HIGH, d);
      chk_rng("alt_high", lo[i], hi[i], d);
    end
    $display("test alternate clocks done");
  endtask

  task automatic t_capture();
    logic [7:0] d;
    wr_reg(T3SA_ADDR_CTRL, 8'h1a);
    wr_reg(T3SA_ADDR_COUNT_LOW, 8'hab);
    wr_reg(T3SA_ADDR_COUNT_HIGH, 8'hcd);
    irq_en = 1'b1;
    @(negedge clk);
    osc = 1'b1;
    repeat (8) @(negedge clk);
    osc = 1'b0;
    repeat (10) @(negedge clk);
    rd_chk("reload_low", T3SA_ADDR_RELOAD_LOW, 8'hab);
    rd_chk("reload_high", T3SA_ADDR_RELOAD_HIGH, 8'hcd);
    chk_irq(1'b1);
    rd_reg(T3SA_ADDR_CTRL, d);
    chk("capture_flag", 8'h80, d & 8'h80);
    wr_reg(T3SA_ADDR_CTRL, 8'h00);
    irq_en = 1'b0;
    $display("test capture done");
  endtask

  // ****************************************************************
  // Verdict, watchdog and main sequence.
  // ****************************************************************
  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", checks, n_fail);
    if ((n_fail == 0) && (checks > 0)) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // The whole run needs about 600 cycles; the watchdog allows more than thirty times that.
  initial begin
    repeat (20000) @(posedge clk);
    $display("Error watchdog expected done seen timeout");
    n_fail++;
    tally_and_finish();
  end

  // Holds reset for 8 cycles, waits out the synchroniser, then runs the scenarios.
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_split_low();
    t_split_high();
    t_irq();
    t_16bit();
    t_alt();
    t_capture();
    tally_and_finish();
  end

endmodule
